//--- design/sgc_top.sv
// Purpose: switch global control register one and the switch-wide
//   decisions it steers (frame pass/drop, pause, back-off, aging)
// Assumes: classic Wishbone slave, 32-bit data; frame info arrives as a
//   one-cycle summary from the MAC on the core clock; link pins are async
// Notes: all outputs registered; register index 2 sits at byte 0x08
// Contract
// RULE1: pass bad frames when sniffing is active
// RULE2: tx pause enable clear blocks pause generation
// RULE3: rx pause enable clear ignores received pause
// RULE4: drop frames whose short length field mismatches
// RULE5: aging enable gates all address aging
// RULE6: fast age bit selects 800 us period
// RULE7: aggressive half-duplex back-off when bit set
// RULE8: ingress overrun sends pause or drops frames
// RULE9: long packets to 2K, else over 2000 dropped
// RULE10: pass flow control packets instead of filtering
// RULE11: link loss triggers one fast age cycle
// RULE12: any cable loss flushes all learned addresses
// RULE13: reserved bits hold writes, no effect
`timescale 1ns/1ns
module sgc_top #(
  parameter int PORTS = 2,
  parameter logic [39:0] AGE_NORM_CYC = sgc_pkg::SGC_AGE_NORM_CYC,
  parameter logic [39:0] AGE_FAST_CYC = sgc_pkg::SGC_AGE_FAST_CYC
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // frame summary from the mac, one-cycle strobe
  input wire logic frame_valid_in,
  input wire logic frame_bad_in,
  input wire logic frame_is_pause_in,
  input wire logic frame_ingress_over_in,
  input wire logic [11:0] frame_len_in,
  input wire logic [15:0] frame_lentype_in,
  input wire logic [15:0] frame_payload_len_in,
  input wire logic sniff_mode_in,
  input wire logic congest_in,
  input wire logic [1:0] second_len_sel_in,
  // link state pins, asynchronous
  input wire logic [PORTS-1:0] link_up_in,
  // decisions
  output logic frame_fwd_out,
  output logic frame_drop_out,
  output logic rx_throttle_out,
  output logic tx_pause_out,
  output logic aggr_backoff_out,
  output logic [1:0] len_sel_out,
  output logic age_tick_out,
  output logic age_flush_out
);

  // reserved bits are plain storage; only named bits steer logic
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] a);
    hit = (adr[7:2] == a[7:2]);
  endfunction

  // bus and register state
  logic [15:0] ctrl_r, ctrl_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] rdat_r, rdat_nxt;
  logic req;

  // link synchronisers: three stages, stable copy when stages 2 and 3 agree
  logic [PORTS-1:0] lnk_s1_r, lnk_s2_r, lnk_s3_r, lnk_st_r;
  logic [PORTS-1:0] lnk_st_nxt;

  // aging state
  logic [39:0] age_cnt_r, age_cnt_nxt;
  logic fast_once_r, fast_once_nxt;
  logic tick_r, tick_nxt;
  logic flush_r, flush_nxt;

  // frame decision state
  logic fwd_r, fwd_nxt;
  logic drop_r, drop_nxt;
  logic thr_r, thr_nxt;
  logic txp_r, txp_nxt;
  logic bo_r, bo_nxt;
  logic [1:0] lsel_r, lsel_nxt;

  // combinational helpers
  logic link_lost;
  logic fast_mode;
  logic [39:0] age_lim;
  logic pass_bad, len_err, too_long, drop_any;

  // a strobe still held after ack is not taken as a second request
  assign req = wb_cyc_in & wb_stb_in & ~ack_r;

  // ---------- register file ----------
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    ack_nxt = req;
    // unmapped reads answer zero but are still acknowledged
    rdat_nxt = 32'h0000_0000;
    if (req && wb_we_in && hit(wb_adr_in, sgc_pkg::SGC_CTRL_ADDR))
    begin
      // byte lanes: sel[0] low byte, sel[1] high byte [RULE13]
      if (wb_sel_in[0])
        ctrl_nxt[7:0] = wb_dat_in[7:0];
      if (wb_sel_in[1])
        ctrl_nxt[15:8] = wb_dat_in[15:8];
    end
    if (req && !wb_we_in)
    begin
      if (hit(wb_adr_in, sgc_pkg::SGC_CTRL_ADDR))
        rdat_nxt = {16'h0000, ctrl_r}; // [RULE13]
      // status word is read-only; a write to it is ignored
      else if (hit(wb_adr_in, sgc_pkg::SGC_STAT_ADDR))
      begin
        rdat_nxt[sgc_pkg::SGC_S_FAST_ONCE] = fast_once_r;
        rdat_nxt[sgc_pkg::SGC_S_LINK_LO +: 2] = 2'(lnk_st_r);
        rdat_nxt[sgc_pkg::SGC_S_AGE_ACT] =
          ctrl_r[sgc_pkg::SGC_B_AGE_EN];
      end
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      ctrl_r <= sgc_pkg::SGC_CTRL_RST;
      ack_r <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      ack_r <= ack_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  // ---------- link synchronisers ----------
  always_comb
  begin
    // a bounce caught in stage two alone never reaches the stable copy
    lnk_st_nxt = lnk_st_r;
    for (int i = 0; i < PORTS; i++)
    begin
      if (lnk_s2_r[i] == lnk_s3_r[i])
        lnk_st_nxt[i] = lnk_s3_r[i];
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      lnk_s1_r <= '0;
      lnk_s2_r <= '0;
      lnk_s3_r <= '0;
      lnk_st_r <= '0;
    end
    else
    begin
      lnk_s1_r <= link_up_in;
      lnk_s2_r <= lnk_s1_r;
      lnk_s3_r <= lnk_s2_r;
      lnk_st_r <= lnk_st_nxt;
    end
  end

  // ---------- aging ----------
  // a port counts as lost on the cycle before its stable copy falls, from its next value
  assign link_lost = |(lnk_st_r & ~lnk_st_nxt);
  // a pending one-shot pass borrows the fast period [RULE11]
  assign fast_mode = ctrl_r[sgc_pkg::SGC_B_FAST_AGE] | fast_once_r;
  assign age_lim = fast_mode ? AGE_FAST_CYC : AGE_NORM_CYC; // [RULE6]

  always_comb
  begin
    age_cnt_nxt = age_cnt_r;
    fast_once_nxt = fast_once_r;
    tick_nxt = 1'b0;
    // unplugging a cable always flushes, whatever the control bits [RULE12]
    flush_nxt = link_lost;
    if (!ctrl_r[sgc_pkg::SGC_B_AGE_EN])
      // held at zero so that re-enabling starts a full period
      age_cnt_nxt = 40'h00_0000_0000; // [RULE5]
    else if (age_cnt_r + 40'h00_0000_0001 >= age_lim)
    begin
      // >= so that switching to fast ends a long normal wait at once
      age_cnt_nxt = 40'h00_0000_0000;
      tick_nxt = 1'b1; // [RULE5]
      if (fast_once_r)
        fast_once_nxt = 1'b0; // one fast cycle, then normal [RULE11]
    end
    else
      age_cnt_nxt = age_cnt_r + 40'h00_0000_0001;
    // a new link loss wins over the clear of the pending fast cycle
    if (link_lost && ctrl_r[sgc_pkg::SGC_B_LINK_AGE])
      fast_once_nxt = 1'b1; // [RULE11]
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      age_cnt_r <= 40'h00_0000_0000;
      fast_once_r <= 1'b0;
      tick_r <= 1'b0;
      flush_r <= 1'b0;
    end
    else
    begin
      age_cnt_r <= age_cnt_nxt;
      fast_once_r <= fast_once_nxt;
      tick_r <= tick_nxt;
      flush_r <= flush_nxt;
    end
  end

  // ---------- frame decisions ----------
  // named control fields, so each decision reads like its rule
  logic f_pass_all, f_tx_pause, f_rx_pause, f_len_chk;
  logic f_aggr_bo, f_pass_fc, f_long_pkt, f_ingr_pause;
  logic drop_bad, drop_ingr, drop_fc, ingr_pause;
  assign f_pass_all = ctrl_r[sgc_pkg::SGC_B_PASS_ALL];
  assign f_tx_pause = ctrl_r[sgc_pkg::SGC_B_TX_PAUSE];
  assign f_rx_pause = ctrl_r[sgc_pkg::SGC_B_RX_PAUSE];
  assign f_len_chk = ctrl_r[sgc_pkg::SGC_B_LEN_CHK];
  assign f_aggr_bo = ctrl_r[sgc_pkg::SGC_B_AGGR_BO];
  assign f_pass_fc = ctrl_r[sgc_pkg::SGC_B_PASS_FC];
  assign f_long_pkt = ctrl_r[sgc_pkg::SGC_B_LONG_PKT];
  assign f_ingr_pause = ctrl_r[sgc_pkg::SGC_B_INGR_PAUSE];

  // bad frames pass only in debug with the sniffer running [RULE1]
  assign pass_bad = f_pass_all & sniff_mode_in;
  assign drop_bad = frame_bad_in & ~pass_bad; // [RULE1]
  // length field is a length only below the limit [RULE4]
  assign len_err = f_len_chk &&
    (frame_lentype_in < sgc_pkg::SGC_LENTYPE_MAX) &&
    (frame_lentype_in != frame_payload_len_in);
  assign too_long = f_long_pkt ?
    (frame_len_in > sgc_pkg::SGC_LEN_LONG_MAX) :
    (frame_len_in > sgc_pkg::SGC_LEN_STD_MAX); // [RULE9]
  // over the ingress limit: pause when chosen, else drop [RULE8]
  assign ingr_pause = frame_ingress_over_in & f_ingr_pause;
  assign drop_ingr = frame_ingress_over_in & ~f_ingr_pause; // [RULE8]
  // flow control frames are filtered unless passing is on [RULE10]
  assign drop_fc = frame_is_pause_in & ~f_pass_fc;
  assign drop_any = drop_bad | len_err | too_long | drop_ingr | drop_fc;

  always_comb
  begin
    fwd_nxt = frame_valid_in & ~drop_any;
    drop_nxt = frame_valid_in & drop_any;
    // received pause acted on only when enabled [RULE3]
    thr_nxt = frame_valid_in & frame_is_pause_in & f_rx_pause;
    // pause on congestion or chosen overrun, never when off [RULE2]
    txp_nxt = f_tx_pause & (congest_in | (frame_valid_in & ingr_pause));
    bo_nxt = f_aggr_bo; // [RULE7]
    // second register's length select has no say with long packets on
    lsel_nxt = f_long_pkt ? 2'b00 : second_len_sel_in; // [RULE9]
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      fwd_r <= 1'b0;
      drop_r <= 1'b0;
      thr_r <= 1'b0;
      txp_r <= 1'b0;
      bo_r <= 1'b0;
      lsel_r <= 2'b00;
    end
    else
    begin
      fwd_r <= fwd_nxt;
      drop_r <= drop_nxt;
      thr_r <= thr_nxt;
      txp_r <= txp_nxt;
      bo_r <= bo_nxt;
      lsel_r <= lsel_nxt;
    end
  end

  assign wb_dat_out = rdat_r;
  assign wb_ack_out = ack_r;
  assign frame_fwd_out = fwd_r;
  assign frame_drop_out = drop_r;
  assign rx_throttle_out = thr_r;
  assign tx_pause_out = txp_r;
  assign aggr_backoff_out = bo_r;
  assign len_sel_out = lsel_r;
  assign age_tick_out = tick_r;
  assign age_flush_out = flush_r;

endmodule // sgc_top

//--- design/sgc_pkg.sv
// Purpose: constants for the switch global control register block
// Assumes: 100 MHz core clock, 32-bit classic Wishbone register access
// Notes: register index times four gives the byte address
package sgc_pkg;
  // register indices and byte addresses
  localparam logic [7:0] SGC_CTRL_IDX = 8'h02;
  localparam logic [7:0] SGC_STAT_IDX = 8'h03;
  localparam logic [7:0] SGC_CTRL_ADDR = 8'h08;
  localparam logic [7:0] SGC_STAT_ADDR = 8'h0C;
  // control field positions
  localparam int SGC_B_PASS_ALL = 15;
  localparam int SGC_B_TX_PAUSE = 13;
  localparam int SGC_B_RX_PAUSE = 12;
  localparam int SGC_B_LEN_CHK = 11;
  localparam int SGC_B_AGE_EN = 10;
  localparam int SGC_B_FAST_AGE = 9;
  localparam int SGC_B_AGGR_BO = 8;
  localparam int SGC_B_PASS_FC = 5;
  localparam int SGC_B_LONG_PKT = 4;
  localparam int SGC_B_INGR_PAUSE = 3;
  localparam int SGC_B_LINK_AGE = 0;
  // status field positions
  localparam int SGC_S_FAST_ONCE = 0;
  localparam int SGC_S_LINK_LO = 1;
  localparam int SGC_S_AGE_ACT = 3;
  // reset value: tx/rx pause, aging and long packets on
  localparam logic [15:0] SGC_CTRL_RST = 16'h3410;
  // frame length limits in bytes
  localparam logic [15:0] SGC_LENTYPE_MAX = 16'h05DC;
  localparam logic [11:0] SGC_LEN_STD_MAX = 12'h7D0;
  localparam logic [11:0] SGC_LEN_LONG_MAX = 12'h800;
  // aging times in their own units
  localparam longint SGC_CLK_MHZ = 100;
  localparam longint SGC_AGE_BASE_S = 300;
  localparam longint SGC_AGE_EXTRA_S = 75;
  localparam longint SGC_FAST_AGE_US = 800;
  localparam logic [39:0] SGC_AGE_NORM_CYC =
    40'((SGC_AGE_BASE_S + SGC_AGE_EXTRA_S) * 1000000 * SGC_CLK_MHZ);
  localparam logic [39:0] SGC_AGE_FAST_CYC =
    40'(SGC_FAST_AGE_US * SGC_CLK_MHZ);
endpackage

//--- tb/sgc_chk.sv
// Purpose: bus and frame decision checks on sgc_top ports
// Assumes: sync active-low reset, one-cycle registered ack
// Notes: control bits are not visible here, so only bit-free relations
`timescale 1ns/1ns
module sgc_chk (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out,
  input wire logic frame_valid_in,
  input wire logic frame_bad_in,
  input wire logic frame_is_pause_in,
  input wire logic frame_ingress_over_in,
  input wire logic [11:0] frame_len_in,
  input wire logic sniff_mode_in,
  input wire logic congest_in,
  input wire logic frame_fwd_out,
  input wire logic frame_drop_out,
  input wire logic rx_throttle_out,
  input wire logic tx_pause_out,
  input wire logic age_flush_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  ack_next_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out
    |=> wb_ack_out) else $error("ack missing");
  ack_once_a: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack held");
  data_idle_a: assert property (!wb_ack_out |-> wb_dat_out == 32'h0)
    else $error("read data outside ack");
  one_verdict_a: assert property (frame_valid_in
    |=> frame_fwd_out != frame_drop_out) else $error("verdict");
  bad_drop_a: assert property (frame_valid_in && frame_bad_in &&
    !sniff_mode_in |=> frame_drop_out) else $error("bad kept");
  long_drop_a: assert property (frame_valid_in && frame_len_in > 12'h800
    |=> frame_drop_out) else $error("long kept");
  pause_quiet_a: assert property (!congest_in && !(frame_valid_in &&
    frame_ingress_over_in) |=> !tx_pause_out) else $error("pause");
  throttle_cause_a: assert property (!(frame_valid_in && frame_is_pause_in)
    |=> !rx_throttle_out) else $error("throttle");
  flush_pulse_a: assert property (age_flush_out |=> !age_flush_out)
    else $error("flush held");
  cover property (frame_drop_out);
  cover property (tx_pause_out);
  cover property (age_flush_out);
endmodule // sgc_chk
bind sgc_top sgc_chk i_chk (.*);

//--- tb/sgc_link_mdl.sv
// Purpose: link partners on the two switch ports
// Assumes: cable state is a plain level per port
// Notes: an unplug is abrupt, as a real cable pull is
`timescale 1ns/1ns
module sgc_link_mdl (
  output logic [1:0] link_up_out
);
  initial link_up_out = 2'h3;
  task unplug(input int p);
    link_up_out[p] <= 1'b0;
  endtask
endmodule // sgc_link_mdl

//--- tb/sgc_top_test.sv
// Purpose: self-checking bench for sgc_top
// Assumes: aging shortened to 200 and 20 cycles
// Notes: bus reads check data inside the read task
`timescale 1ns/1ns
module sgc_top_test;
  logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic fv = 1'b0, bad = 1'b0, pse = 1'b0, ovr = 1'b0, snf = 1'b0;
  logic cng = 1'b0;
  logic [7:0] adr = 8'h0;
  logic [31:0] dat = 32'h0, rdat, wdo;
  logic [11:0] len = 12'h40;
  logic [15:0] lt = 16'h0800, pl = 16'h0;
  logic ack, fwd, drp, thr, txp, abo, tick, fl;
  logic [1:0] lsel, link;
  int error_cnt = 0, total_checks = 0;
  always #5 clk = ~clk;
  sgc_link_mdl i_lp (.link_up_out(link));
  sgc_top #(.AGE_NORM_CYC(40'hC8), .AGE_FAST_CYC(40'h14)) i_dut (
    .core_clk_in(clk), .rst_n_in(rst_n), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'h3),
    .wb_dat_in(dat), .wb_dat_out(wdo), .wb_ack_out(ack),
    .frame_valid_in(fv), .frame_bad_in(bad), .frame_is_pause_in(pse),
    .frame_ingress_over_in(ovr), .frame_len_in(len),
    .frame_lentype_in(lt), .frame_payload_len_in(pl),
    .sniff_mode_in(snf), .congest_in(cng), .second_len_sel_in(2'h1),
    .link_up_in(link), .frame_fwd_out(fwd), .frame_drop_out(drp),
    .rx_throttle_out(thr), .tx_pause_out(txp), .aggr_backoff_out(abo),
    .len_sel_out(lsel), .age_tick_out(tick), .age_flush_out(fl));
  task test_done;
    if (error_cnt == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, g);
    total_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("ERROR %s exp %h got %h", n, e, g);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    if (n == 20)
      chk("bus timeout", 1, 0);
    if (n == 20)
      test_done;
    rdat = wdo;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk("read data", e, rdat);
  endtask
  // f is {bad, pause, over, sniff}; e is {drop, throttle, tx pause}
  task fr(input logic [3:0] f, input logic [11:0] l,
    input logic [15:0] t, p, input logic [2:0] e);
    @(posedge clk);
    {bad, pse, ovr, snf} <= f;
    len <= l;
    lt <= t;
    pl <= p;
    fv <= 1'b1;
    @(posedge clk);
    fv <= 1'b0;
    @(posedge clk);
    chk("frame verdict", {29'h0, e}, {29'h0, drp, thr, txp});
  endtask
  // one cycle of congestion with no frame; e is the expected tx pause
  task cong(input logic e);
    @(posedge clk);
    cng <= 1'b1;
    @(posedge clk);
    cng <= 1'b0;
    @(posedge clk);
    chk("congest pause", {31'h0, e}, {31'h0, txp});
  endtask
  // a bound run out reads back as 999, meaning no tick at all
  task age(input int e);
    int n;
    n = 0;
    while (tick !== 1'b1 && n < 999)
    begin
      @(posedge clk);
      n++;
    end
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (tick !== 1'b1 && n < 999);
    chk("age period", e, n);
  endtask
  task t_frames;
    fr(4'h8, 12'h40, 16'h0800, 16'h0, 3'h4);
    fr(4'h9, 12'h40, 16'h0800, 16'h0, 3'h4);
    bus(1'b1, 8'h08, 32'hB438);
    fr(4'h9, 12'h40, 16'h0800, 16'h0, 3'h0);
    fr(4'h4, 12'h40, 16'h0800, 16'h0, 3'h2);
    fr(4'h2, 12'h40, 16'h0800, 16'h0, 3'h1);
    fr(4'h0, 12'h800, 16'h0800, 16'h0, 3'h0);
    fr(4'h0, 12'h801, 16'h0800, 16'h0, 3'h4);
    chk("len select", 2'h0, lsel);
    bus(1'b1, 8'h08, 32'h0828);
    @(posedge clk);
    chk("len select", 2'h1, lsel);
    cong(1'b0);
    fr(4'h4, 12'h40, 16'h0800, 16'h0, 3'h0);
    fr(4'h2, 12'h40, 16'h0800, 16'h0, 3'h0);
    fr(4'h0, 12'h7D0, 16'h0800, 16'h0, 3'h0);
    fr(4'h0, 12'h7D1, 16'h0800, 16'h0, 3'h4);
    fr(4'h0, 12'h40, 16'h0064, 16'h0063, 3'h4);
    fr(4'h0, 12'h40, 16'h0064, 16'h0064, 3'h0);
    bus(1'b1, 8'h08, 32'h3500);
    cong(1'b1);
    fr(4'h2, 12'h40, 16'h0800, 16'h0, 3'h4);
    fr(4'h4, 12'h40, 16'h0800, 16'h0, 3'h6);
    chk("backoff", 1, abo);
  endtask
  task t_link;
    int n;
    bus(1'b1, 8'h08, 32'h3411);
    i_lp.unplug(0);
    n = 0;
    while (fl !== 1'b1 && n < 9)
    begin
      @(posedge clk);
      n++;
    end
    chk("flush", 1, fl);
    n = 0;
    while (tick !== 1'b1 && n < 99)
    begin
      @(posedge clk);
      n++;
    end
    chk("fast once", 1, n <= 21);
    age(200);
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h08, 32'h3410);
    bus(1'b1, 8'h08, 32'hFFFF4006);
    rd(8'h08, 32'h4006);
    bus(1'b1, 8'h40, 32'h1234);
    rd(8'h40, 32'h0);
    t_frames;
    bus(1'b1, 8'h08, 32'h3410);
    age(200);
    bus(1'b1, 8'h08, 32'h3610);
    age(20);
    bus(1'b1, 8'h08, 32'h3010);
    age(999);
    t_link;
    test_done;
  end
endmodule // sgc_top_test
